// *** rtl/rsm_pkg.sv ***
// rsm_pkg: constants and carrier types for the road switch monitor
// assumes measurements arrive already digitized in mV, ohm and mA
package rsm_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS_DIV = CLK_HZ / 1000;
  localparam logic [15:0] OFFROAD_LO_MV = 16'd4700;
  localparam logic [15:0] OFFROAD_HI_MV = 16'd5300;
  localparam logic [15:0] ONROAD_MAX_MV = 16'd500;
  localparam logic [15:0] SUPPLY_NOM_MV = 16'd5000;
  localparam logic [15:0] RES_OPEN_MIN_OHM = 16'd200;
  localparam logic [15:0] RES_CLOSED_LO_OHM = 16'd20;
  localparam logic [15:0] RES_CLOSED_HI_OHM = 16'd70;
  localparam logic [15:0] RES_UNDEF_LO_OHM = 16'd100;
  localparam logic [15:0] OVERCURRENT_MA = 16'd2000;
  localparam int unsigned FAULT_TIME_MS = 100;
  localparam logic [7:0] CODE_ENABLE = 8'hFF;
  localparam logic [7:0] CODE_DISABLE = 8'h00;
  localparam int unsigned PULSE_PERIOD_MS = 10;
  localparam logic [15:0] PULSE_CURRENT_MA = 16'd50;
  localparam int unsigned CNT_W = 8;

  typedef enum logic [1:0] {RSM_POS_UNDEF, RSM_POS_OFF, RSM_POS_ON} rsm_pos_t;
  typedef enum logic [1:0] {RSM_VAR_NONE, RSM_VAR_COV, RSM_VAR_RES} rsm_var_t;

  typedef struct packed {
    logic valid;
    logic [15:0] volt_mv;
    logic [15:0] supply_mv;
    logic [15:0] res_ohm;
    logic [15:0] cur_ma;
  } rsm_meas_t;

  typedef struct packed {
    logic safe_req;
    logic cutoff_drive;
    logic test_pulse;
    logic bridge_enable;
    logic offroad;
  } rsm_out_t;
endpackage

// *** rtl/rsm_timer.sv ***
// rsm_timer: counts millisecond ticks while a fault condition holds
// assumes tick is a one-cycle pulse from the millisecond divider
`timescale 1ns/1ps
module rsm_timer import rsm_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic cond,
  output logic expired
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic exp;
  } rsm_tmr_st_t;
  rsm_tmr_st_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!cond) begin
      nxt_st.cnt = '0; // restart on clear
      nxt_st.exp = 1'b0;
    end else if (tick) begin
      if (nxt_st.cnt > CNT_W'(FAULT_TIME_MS)) begin
        nxt_st.exp = 1'b1; // strictly longer than limit
      end else begin
        nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expired = st_ff.exp;
endmodule // rsm_timer

// *** rtl/rsm_top.sv ***
// rsm_top: road switch monitor, classification and safe-state latch
// assumes digitized inputs with a valid strobe and static configuration codes
//
// Overview of operation
// - voltage strictly inside 4700..5300 mV is off-road
// - voltage below 500 mV is on-road
// - voltage outside both windows >100 ms faults
// - supply rail above nominal requests safe state
// - cut-off variant on-road: power off, test pulses
// - current build-up on test pulse faults
// - cut-off variant off-road: stop pulses, supply current
// - off-road current below half set-point faults
// - resistance >200 open, strictly inside 20..70 closed
// - resistance 100..200 for >100 ms faults
// - output current above 2 A faults
// - channel disagreement for >100 ms faults
// - relay channel resistance from output current
// - resistor variant bridge energized only off-road
// - resistance check disabled ignores resistance input
// - open voltage input reads as on-road
// - resistor variant selected by parameter codes
// - cut-off variant requires resistance check zero
`timescale 1ns/1ps
module rsm_top import rsm_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input rsm_meas_t meas,
  input wire logic [15:0] cur_setpoint_ma,
  input wire logic [7:0] cutoff_valve_present,
  input wire logic [7:0] road_switch_present,
  input wire logic [7:0] res_check_code,
  output rsm_out_t outs,
  output rsm_pos_t voltage_side_switch,
  output rsm_pos_t relay_side_switch,
  output rsm_var_t variant
);
  typedef struct packed {
    logic [17:0] div;
    logic tick;
    logic [15:0] volt;
    logic [15:0] supply;
    logic [15:0] res;
    logic [15:0] cur;
    logic [3:0] pulse_ms;
    logic pulse;
    logic latch;
    logic fault_now;
    rsm_out_t prev_o;
    rsm_out_t o;
  } rsm_st_t;
  rsm_st_t st_ff, nxt_st;

  rsm_var_t var_sel;
  rsm_pos_t pos_v;
  rsm_pos_t pos_r;
  logic v_undef;
  logic r_undef;
  logic disagree;
  logic v_exp;
  logic r_exp;
  logic d_exp;
  logic mode_off;

  // divider must hold a full millisecond of clocks, so it is wider than the timers
  localparam logic [17:0] DIV_LAST = 18'(TICK_MS_DIV - 1);
  localparam logic [3:0] PULSE_LAST = 4'(PULSE_PERIOD_MS - 1);

  always_comb begin
    if (cutoff_valve_present == CODE_DISABLE && road_switch_present == CODE_ENABLE
        && res_check_code == CODE_ENABLE) begin
      var_sel = RSM_VAR_RES;
    end else if (cutoff_valve_present == CODE_ENABLE && road_switch_present == CODE_ENABLE
                 && res_check_code == CODE_DISABLE) begin
      var_sel = RSM_VAR_COV;
    end else begin
      var_sel = RSM_VAR_NONE;
    end
  end

  // reset value 0 mV reads as on-road, like the pulled-down open input
  always_comb begin
    if (st_ff.volt > OFFROAD_LO_MV && st_ff.volt < OFFROAD_HI_MV) begin
      pos_v = RSM_POS_OFF;
    end else if (st_ff.volt < ONROAD_MAX_MV) begin
      pos_v = RSM_POS_ON;
    end else begin
      pos_v = RSM_POS_UNDEF;
    end
  end

  // resistance comes from the high-side current measurement upstream
  always_comb begin
    if (st_ff.res > RES_OPEN_MIN_OHM) begin
      pos_r = RSM_POS_OFF;
    end else if (st_ff.res > RES_CLOSED_LO_OHM && st_ff.res < RES_CLOSED_HI_OHM) begin
      pos_r = RSM_POS_ON;
    end else begin
      pos_r = RSM_POS_UNDEF;
    end
  end

  // voltage input fault timed only when a variant is selected (cut-off or resistor)
  assign v_undef = (var_sel != RSM_VAR_NONE) && (pos_v == RSM_POS_UNDEF);
  assign r_undef = (var_sel == RSM_VAR_RES) && st_ff.res >= RES_UNDEF_LO_OHM
                   && st_ff.res <= RES_OPEN_MIN_OHM;
  assign disagree = (var_sel == RSM_VAR_RES) && (pos_v != pos_r);
  // fault_now also blocks drives so they drop in the same cycle safe_req rises
  assign mode_off = (pos_v == RSM_POS_OFF) && !st_ff.latch && !st_ff.fault_now;

  rsm_timer u_tmr_volt (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(st_ff.tick),
    .cond(v_undef),
    .expired(v_exp)
  );

  rsm_timer u_tmr_res (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(st_ff.tick),
    .cond(r_undef),
    .expired(r_exp)
  );

  rsm_timer u_tmr_xchk (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(st_ff.tick),
    .cond(disagree),
    .expired(d_exp)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.div == DIV_LAST) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 18'd1;
    end
    if (meas.valid) begin
      nxt_st.volt = meas.volt_mv;
      nxt_st.supply = meas.supply_mv;
      nxt_st.res = meas.res_ohm;
      nxt_st.cur = meas.cur_ma;
    end
    // pulse pattern: one ms high every period
    if (st_ff.tick) begin
      if (st_ff.pulse_ms == PULSE_LAST) begin
        nxt_st.pulse_ms = '0;
      end else begin
        nxt_st.pulse_ms = st_ff.pulse_ms + 4'd1;
      end
    end
    nxt_st.pulse = (st_ff.pulse_ms == 4'd0);
    nxt_st.fault_now = 1'b0;
    if (st_ff.supply > SUPPLY_NOM_MV) begin
      nxt_st.fault_now = 1'b1;
    end
    if (st_ff.cur > OVERCURRENT_MA) begin
      nxt_st.fault_now = 1'b1;
    end
    if (v_exp || r_exp || d_exp) begin
      nxt_st.fault_now = 1'b1;
    end
    if (var_sel == RSM_VAR_COV) begin
      // only pulses already on the wire count, so stale samples of supply phase are skipped
      // output must have stood a cycle, else the sample still shows the previous phase
      if (st_ff.o.test_pulse && st_ff.prev_o.test_pulse && st_ff.cur > PULSE_CURRENT_MA) begin
        nxt_st.fault_now = 1'b1;
      end
      if (st_ff.o.cutoff_drive && st_ff.prev_o.cutoff_drive && st_ff.cur < (cur_setpoint_ma >> 1)
          && pos_v == RSM_POS_OFF) begin
        nxt_st.fault_now = 1'b1;
      end
    end
    if (st_ff.fault_now) begin
      nxt_st.latch = 1'b1; // held until reset
    end
    nxt_st.prev_o = st_ff.o;
    nxt_st.o.safe_req = st_ff.latch || st_ff.fault_now;
    nxt_st.o.offroad = mode_off;
    nxt_st.o.cutoff_drive = (var_sel == RSM_VAR_COV) && mode_off;
    nxt_st.o.test_pulse = (var_sel == RSM_VAR_COV) && !mode_off && st_ff.pulse;
    nxt_st.o.bridge_enable = mode_off && (var_sel == RSM_VAR_RES ? pos_r == RSM_POS_OFF : 1'b1);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign outs = st_ff.o;
  assign voltage_side_switch = pos_v;
  assign relay_side_switch = pos_r;
  assign variant = var_sel;
endmodule // rsm_top

// *** testbench/rsm_top_assertions.sv ***
// rsm_top_checker: port-level properties of the monitor
// assumes bound into rsm_top, one clock domain
`timescale 1ns/1ps
module rsm_top_checker import rsm_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input rsm_meas_t meas,
  input rsm_out_t outs,
  input rsm_pos_t voltage_side_switch,
  input rsm_pos_t relay_side_switch,
  input rsm_var_t variant
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic v;
  logic res_v;
  assign v = meas.valid;
  assign res_v = meas.valid && variant == RSM_VAR_RES;
  AST_STICKY: assert property (outs.safe_req |=> outs.safe_req)
    else $error("safe request dropped");
  AST_OVERCUR: assert property (v && meas.cur_ma > 16'h07D0 |-> ##[1:3] outs.safe_req)
    else $error("overcurrent ignored");
  AST_SUPPLY: assert property (v && meas.supply_mv > 16'h1388 |-> ##[1:3] outs.safe_req)
    else $error("supply fault ignored");
  AST_SAFE_OFF: assert property (outs.safe_req |-> !outs.cutoff_drive && !outs.bridge_enable)
    else $error("drive on in safe state");
  AST_VOLT_OFF: assert property (v && meas.volt_mv > 16'h125C && meas.volt_mv < 16'h14B4
    |=> voltage_side_switch == RSM_POS_OFF) else $error("off-road voltage misread");
  AST_VOLT_ON: assert property (v && meas.volt_mv < 16'h01F4 |=> voltage_side_switch == RSM_POS_ON)
    else $error("on-road voltage misread");
  AST_RES_OPEN: assert property (res_v && meas.res_ohm > 16'h00C8 |=> relay_side_switch == RSM_POS_OFF)
    else $error("open switch misread");
  AST_BRIDGE: assert property (variant == RSM_VAR_RES && voltage_side_switch == RSM_POS_ON
    |-> ##[1:2] !outs.bridge_enable) else $error("bridge on in on-road");
  COV_SAFE: cover property ($rose(outs.safe_req));
  COV_BRIDGE: cover property (outs.bridge_enable);
  COV_DRIVE: cover property (outs.cutoff_drive);
endmodule // rsm_top_checker
bind rsm_top rsm_top_checker rsm_top_checker_i (.mclk(mclk), .arst_n(arst_n), .meas(meas), .outs(outs),
  .voltage_side_switch(voltage_side_switch), .relay_side_switch(relay_side_switch), .variant(variant));

// *** testbench/rsm_field.sv ***
// rsm_field: switches, relays and load resistor seen by the monitor
// assumes bench picks the switch position or forces raw readings
`timescale 1ns/1ps
module rsm_field import rsm_pkg::*; (
  input wire logic mclk,
  input wire logic sw_off,
  input wire logic drive,
  input wire logic frc,
  input rsm_meas_t fv,
  output rsm_meas_t meas
);
  rsm_meas_t r;
  // open input pulled low; closed switch loads 40 ohm, driven output draws 600 mA
  always_ff @(posedge mclk) begin
    r <= frc ? fv : '{1'b1, sw_off ? 16'h1388 : 16'h0000, 16'h1388, sw_off ? 16'hFFFF : 16'h0028, 16'h0000};
  end
  assign meas = '{r.valid, r.volt_mv, r.supply_mv, r.res_ohm, frc ? r.cur_ma : (drive ? 16'h0258 : 16'h0000)};
endmodule // rsm_field

// *** testbench/rsm_top_tb.sv ***
// rsm_top_tb: self-checking bench for the road switch monitor
// assumes rsm_field as the switch wiring model
`timescale 1ns/1ps
module rsm_top_tb import rsm_pkg::*; ;
  logic mclk = 0, arst_n = 0, sw_off = 0, frc = 0;
  logic [15:0] sp = 16'h03E8;
  logic [7:0] cvp = 8'hFF, rsp = 8'hFF, rcc = 8'h00;
  rsm_meas_t fv = '0, meas;
  rsm_out_t outs;
  rsm_pos_t vss, rss;
  rsm_var_t var_o;
  int miscompares = 0, n_checks = 0;
  always #2.5 mclk = ~mclk;
  rsm_field rsm_field_i (.mclk(mclk), .sw_off(sw_off), .drive(outs.cutoff_drive), .frc(frc), .fv(fv), .meas(meas));
  rsm_top rsm_top_i (.mclk(mclk), .arst_n(arst_n), .meas(meas), .cur_setpoint_ma(sp), .cutoff_valve_present(cvp),
    .road_switch_present(rsp), .res_check_code(rcc), .outs(outs), .voltage_side_switch(vss),
    .relay_side_switch(rss), .variant(var_o));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge mclk);
    arst_n <= 1'b0;
    frc <= 1'b0;
    sw_off <= 1'b0;
    cvp <= a;
    rsp <= b;
    rcc <= c;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
  endtask
  // reading goes through the model register, then capture, then fault latch
  task automatic put(input logic [15:0] v, input logic [15:0] r, input logic [15:0] c, input logic [15:0] s);
    @(posedge mclk);
    frc <= 1'b1;
    fv <= '{1'b1, v, s, r, c};
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic t_variant;
    rst(8'hFF, 8'hFF, 8'h00);
    chk(16'(var_o), 16'(RSM_VAR_COV));
    chk(16'(vss), 16'(RSM_POS_ON));
    rst(8'h00, 8'hFF, 8'hFF);
    chk(16'(var_o), 16'(RSM_VAR_RES));
    rst(8'h00, 8'hFF, 8'h00);
    chk(16'(var_o), 16'(RSM_VAR_NONE));
    $display("variant done");
  endtask
  task automatic t_class;
    logic [15:0] vt[6] = '{16'h125D, 16'h14B3, 16'h125C, 16'h14B4, 16'h01F3, 16'h01F4};
    logic [15:0] rt[6] = '{16'h00C9, 16'h00C8, 16'h0015, 16'h0045, 16'h0014, 16'h0046};
    rsm_pos_t ve[6] = '{RSM_POS_OFF, RSM_POS_OFF, RSM_POS_UNDEF, RSM_POS_UNDEF, RSM_POS_ON, RSM_POS_UNDEF};
    rsm_pos_t re[6] = '{RSM_POS_OFF, RSM_POS_UNDEF, RSM_POS_ON, RSM_POS_ON, RSM_POS_UNDEF, RSM_POS_UNDEF};
    rst(8'h00, 8'hFF, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      put(vt[i], rt[i], 16'h0000, 16'h1388);
      chk(16'(vss), 16'(ve[i]));
      chk(16'(rss), 16'(re[i]));
    end
    $display("class done");
  endtask
  task automatic t_modes;
    rst(8'h00, 8'hFF, 8'hFF);
    sw_off <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk({outs.bridge_enable, outs.offroad}, 16'h0003);
    sw_off <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk(16'(outs.bridge_enable), 16'h0000);
    rst(8'hFF, 8'hFF, 8'h00);
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(outs.test_pulse), 16'h0001);
    sw_off <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk({outs.cutoff_drive, outs.test_pulse, outs.safe_req}, 16'h0004);
    sp <= 16'h0578;
    repeat (8) @(posedge mclk);
    #1;
    chk({outs.safe_req, outs.cutoff_drive}, 16'h0002);
    sp <= 16'h03E8;
    $display("modes done");
  endtask
  task automatic t_fault;
    rst(8'h00, 8'hFF, 8'hFF);
    put(16'h0000, 16'hFFFF, 16'h07D0, 16'h1388);
    chk(16'(outs.safe_req), 16'h0000);
    put(16'h0000, 16'hFFFF, 16'h07D1, 16'h1388);
    chk(16'(outs.safe_req), 16'h0001);
    put(16'h0000, 16'hFFFF, 16'h0000, 16'h1388);
    chk(16'(outs.safe_req), 16'h0001);
    rst(8'h00, 8'hFF, 8'hFF);
    chk(16'(outs.safe_req), 16'h0000);
    put(16'h0000, 16'hFFFF, 16'h0000, 16'h1389);
    chk(16'(outs.safe_req), 16'h0001);
    rst(8'hFF, 8'hFF, 8'h00);
    put(16'h0000, 16'h0000, 16'h0033, 16'h1388);
    chk(16'(outs.safe_req), 16'h0001);
    $display("fault done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_variant();
    t_class();
    t_modes();
    t_fault();
    finish_test();
  end
  // all tests need well under a thousand cycles
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end
endmodule // rsm_top_tb
